// [hdl/dsp_pkg.sv]
package dsp_pkg;

    // ************************************************************
    // Field widths
    // ************************************************************
    localparam int CMD_W  = 8;
    localparam int WORD_W = 16;

    // ************************************************************
    // Command encoding
    // ************************************************************
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_READ  = 8'h03;

    // ************************************************************
    // Bit counter end points
    // ************************************************************
    localparam logic [3:0] CMD_LAST_BIT  = 4'h7;
    localparam logic [3:0] WORD_LAST_BIT = 4'hf;
    localparam logic [3:0] BIT_RST       = 4'h0;

    // ************************************************************
    // Read pipeline: filler words before data, words held ahead
    // ************************************************************
    localparam logic [1:0] TURN_WORDS = 2'h2;
    localparam logic [1:0] PREFETCH   = 2'h2;
    localparam logic [1:0] CNT_RST    = 2'h0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  CMD_RST  = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ************************************************************
    // State types
    // ************************************************************
    typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA} dsp_phase_e;
    typedef enum logic [1:0] {SS_IDLE, SS_WRITE, SS_READ} dsp_mode_e;

endpackage

// [hdl/dsp_sync.sv]
`timescale 1ns/1ns
// Two-stage level synchroniser; first stage feeds only the second
module dsp_sync
    import dsp_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // ************************************************************
    // Per-bit stages
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            // No reset: value settles after two edges
            always_ff @(posedge clk_in)
            begin
                meta_r[gi] <= async_in[gi];
                sync_r[gi] <= meta_r[gi];
            end
        end
    endgenerate

    assign sync_out = sync_r;

endmodule

// [hdl/dsp_tgl_pulse.sv]
`timescale 1ns/1ns
// Toggle event crossing: one-cycle pulse per toggle seen
module dsp_tgl_pulse
    import dsp_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic tgl_in,
    output logic      pulse_out
);

    logic meta_r;
    logic sync_r;
    logic hist_r;
    logic meta_nxt;
    logic sync_nxt;
    logic hist_nxt;

    // Next values; edge detect compares the second stage with the third
    always_comb
    begin
        meta_nxt = tgl_in;
        sync_nxt = meta_r;
        hist_nxt = sync_r;
    end

    // Registers
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            hist_r <= 1'b0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            hist_r <= hist_nxt;
        end
    end

    assign pulse_out = sync_r ^ hist_r;

endmodule

// [hdl/dsp_top.sv]
`timescale 1ns/1ns
module dsp_top
    import dsp_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    input  wire logic        link_clk_in,
    input  wire logic        link_cs_n_in,
    input  wire logic        link_mosi_in,
    output logic             link_miso_out,
    output logic             link_miso_oe_out,
    input  wire logic        port_enable_select_in,
    input  wire logic        cpu_halted_in,
    output logic             mem_req_out,
    output logic             mem_we_out,
    output logic [15:0]      mem_addr_out,
    output logic [15:0]      mem_wdata_out,
    input  wire logic [15:0] mem_rdata_in,
    input  wire logic        mem_ack_in
);

    // ************************************************************
    // Link domain declarations
    // ************************************************************
    logic              link_rst_n;
    dsp_phase_e        ph_r;
    dsp_phase_e        ph_nxt;
    logic [3:0]        bit_r;
    logic [3:0]        bit_nxt;
    logic [15:0]       shin_r;
    logic [15:0]       shin_nxt;
    logic [15:0]       shin_sh;
    logic [7:0]        cmd_r;
    logic [7:0]        cmd_nxt;
    logic [15:0]       addr_hold_r;
    logic [15:0]       addr_hold_nxt;
    logic [15:0]       wr_hold_r;
    logic [15:0]       wr_hold_nxt;
    logic [15:0]       shout_r;
    logic [15:0]       shout_nxt;
    logic [1:0]        slot_r;
    logic [1:0]        slot_nxt;
    logic              lpar_r;
    logic              lpar_nxt;
    logic              start_tgl_r;
    logic              start_tgl_nxt;
    logic              wr_tgl_r;
    logic              wr_tgl_nxt;
    logic              take_tgl_r;
    logic              take_tgl_nxt;
    logic              load_slot;
    logic              miso_link_r;
    logic              miso_link_nxt;

    // ************************************************************
    // System domain declarations
    // ************************************************************
    logic              start_p;
    logic              wr_p;
    logic              take_p;
    logic              enable_sync;
    dsp_mode_e         mode_r;
    dsp_mode_e         mode_nxt;
    logic [15:0]       addr_r;
    logic [15:0]       addr_nxt;
    logic [1:0]        pend_r;
    logic [1:0]        pend_nxt;
    logic              fill_par_r;
    logic              fill_par_nxt;
    logic              req_r;
    logic              req_nxt;
    logic              we_r;
    logic              we_nxt;
    logic [15:0]       maddr_r;
    logic [15:0]       maddr_nxt;
    logic [15:0]       wdata_r;
    logic [15:0]       wdata_nxt;
    logic [15:0]       rd_buf_r   [0:1];
    logic [15:0]       rd_buf_nxt [0:1];
    logic              idle_r;
    logic              idle_nxt;
    logic              oe_r;
    logic              oe_nxt;

    // ************************************************************
    // Link side: shifter and phase tracking
    // ************************************************************

    // Link reset follows system reset; master must clock during it
    dsp_sync #(.W(1)) u_link_rst (
        .clk_in   (link_clk_in),
        .async_in (reset_n_in),
        .sync_out (link_rst_n)
    );

    // Next-state of the link shifter
    always_comb
    begin
        ph_nxt        = ph_r;
        bit_nxt       = bit_r;
        shin_nxt      = shin_r;
        cmd_nxt       = cmd_r;
        addr_hold_nxt = addr_hold_r;
        wr_hold_nxt   = wr_hold_r;
        shout_nxt     = shout_r;
        slot_nxt      = slot_r;
        lpar_nxt      = lpar_r;
        start_tgl_nxt = start_tgl_r;
        wr_tgl_nxt    = wr_tgl_r;
        take_tgl_nxt  = take_tgl_r;
        load_slot     = 1'b0;
        shin_sh       = {shin_r[14:0], link_mosi_in};
        if (link_cs_n_in)
        begin
            ph_nxt    = PH_CMD;
            bit_nxt   = BIT_RST;
            slot_nxt  = CNT_RST;
            lpar_nxt  = 1'b0;
            shout_nxt = WORD_RST;
        end
        else
        begin
            shin_nxt  = shin_sh;
            bit_nxt   = 4'(bit_r + 4'h1);
            shout_nxt = {shout_r[14:0], 1'b0};
            unique case (ph_r)
                PH_CMD:
                begin
                    if (bit_r == CMD_LAST_BIT)
                    begin
                        cmd_nxt = shin_sh[7:0];
                        ph_nxt  = PH_ADDR;
                        bit_nxt = BIT_RST;
                    end
                end
                PH_ADDR:
                begin
                    if (bit_r == WORD_LAST_BIT)
                    begin
                        addr_hold_nxt = shin_sh;
                        start_tgl_nxt = ~start_tgl_r;
                        ph_nxt        = PH_DATA;
                        load_slot     = 1'b1;
                    end
                end
                PH_DATA:
                begin
                    if (bit_r == WORD_LAST_BIT)
                    begin
                        load_slot = 1'b1;
                        if (cmd_r == CMD_WRITE)
                        begin
                            wr_hold_nxt = shin_sh;
                            wr_tgl_nxt  = ~wr_tgl_r;
                        end
                    end
                end
                default:
                begin
                    ph_nxt = PH_CMD;
                end
            endcase
            // Reply word load; filler words cover fetch latency
            if (load_slot && (cmd_r == CMD_READ))
            begin
                if (slot_r < TURN_WORDS)
                begin
                    slot_nxt  = 2'(slot_r + 2'h1);
                    shout_nxt = WORD_RST;
                end
                else
                begin
                    shout_nxt    = rd_buf_r[lpar_r];
                    lpar_nxt     = ~lpar_r;
                    take_tgl_nxt = ~take_tgl_r;
                end
            end
        end
    end

    // Link registers; toggles survive frames so crossings stay paired
    // master clock drives link
    always_ff @(posedge link_clk_in)
    begin
        if (!link_rst_n)
        begin
            ph_r        <= PH_CMD;
            bit_r       <= BIT_RST;
            shin_r      <= WORD_RST;
            cmd_r       <= CMD_RST;
            addr_hold_r <= WORD_RST;
            wr_hold_r   <= WORD_RST;
            shout_r     <= WORD_RST;
            slot_r      <= CNT_RST;
            lpar_r      <= 1'b0;
            start_tgl_r <= 1'b0;
            wr_tgl_r    <= 1'b0;
            take_tgl_r  <= 1'b0;
        end
        else
        begin
            ph_r        <= ph_nxt;
            bit_r       <= bit_nxt;
            shin_r      <= shin_nxt;
            cmd_r       <= cmd_nxt;
            addr_hold_r <= addr_hold_nxt;
            wr_hold_r   <= wr_hold_nxt;
            shout_r     <= shout_nxt;
            slot_r      <= slot_nxt;
            lpar_r      <= lpar_nxt;
            start_tgl_r <= start_tgl_nxt;
            wr_tgl_r    <= wr_tgl_nxt;
            take_tgl_r  <= take_tgl_nxt;
        end
    end

    always_comb
    begin
        miso_link_nxt = link_cs_n_in ? 1'b0 : shout_r[15];
    end

    always_ff @(negedge link_clk_in)
    begin
        if (!link_rst_n)
            miso_link_r <= 1'b0;
        else
            miso_link_r <= miso_link_nxt;
    end

    // ************************************************************
    // Crossings into the system clock
    // ************************************************************
    dsp_tgl_pulse u_start (
        .clk_in     (clk_sys_in),
        .reset_n_in (reset_n_in),
        .tgl_in     (start_tgl_r),
        .pulse_out  (start_p)
    );

    dsp_tgl_pulse u_wr (
        .clk_in     (clk_sys_in),
        .reset_n_in (reset_n_in),
        .tgl_in     (wr_tgl_r),
        .pulse_out  (wr_p)
    );

    dsp_tgl_pulse u_take (
        .clk_in     (clk_sys_in),
        .reset_n_in (reset_n_in),
        .tgl_in     (take_tgl_r),
        .pulse_out  (take_p)
    );

    dsp_sync #(.W(1)) u_en (
        .clk_in   (clk_sys_in),
        .async_in (port_enable_select_in),
        .sync_out (enable_sync)
    );

    // ************************************************************
    // System side: memory access sequencer
    // ************************************************************

    // Held words are stable by protocol when the pulse lands
    always_comb
    begin
        mode_nxt     = mode_r;
        addr_nxt     = addr_r;
        pend_nxt     = pend_r;
        fill_par_nxt = fill_par_r;
        req_nxt      = req_r;
        we_nxt       = we_r;
        maddr_nxt    = maddr_r;
        wdata_nxt    = wdata_r;
        rd_buf_nxt   = rd_buf_r;
        idle_nxt     = cpu_halted_in;
        oe_nxt       = enable_sync;
        if (req_r && mem_ack_in)
        begin
            req_nxt  = 1'b0;
            addr_nxt = 16'(addr_r + 16'h0001);
            if (!we_r)
            begin
                rd_buf_nxt[fill_par_r] = mem_rdata_in;
                fill_par_nxt           = ~fill_par_r;
            end
        end
        if (start_p)
        begin
            unique case (cmd_r)
                CMD_WRITE: mode_nxt = SS_WRITE;
                CMD_READ:  mode_nxt = SS_READ;
                default:   mode_nxt = SS_IDLE;
            endcase
            addr_nxt     = addr_hold_r;
            pend_nxt     = (cmd_r == CMD_READ) ? PREFETCH : CNT_RST;
            fill_par_nxt = 1'b0;
        end
        else
        begin
            if (wr_p && (mode_r == SS_WRITE))
            begin
                req_nxt   = 1'b1;
                we_nxt    = 1'b1;
                maddr_nxt = addr_r;
                wdata_nxt = wr_hold_r;
            end
            else if ((mode_r == SS_READ) && !req_r && (pend_r != CNT_RST))
            begin
                req_nxt   = 1'b1;
                we_nxt    = 1'b0;
                maddr_nxt = addr_r;
                pend_nxt  = 2'(pend_nxt - 2'h1);
            end
            if (take_p && (mode_r == SS_READ))
                pend_nxt = 2'(pend_nxt + 2'h1);
        end
    end

    // System registers
    always_ff @(posedge clk_sys_in)
    begin
        if (!reset_n_in)
        begin
            mode_r      <= SS_IDLE;
            addr_r      <= WORD_RST;
            pend_r      <= CNT_RST;
            fill_par_r  <= 1'b0;
            req_r       <= 1'b0;
            we_r        <= 1'b0;
            maddr_r     <= WORD_RST;
            wdata_r     <= WORD_RST;
            rd_buf_r[0] <= WORD_RST;
            rd_buf_r[1] <= WORD_RST;
            idle_r      <= 1'b0;
            oe_r        <= 1'b0;
        end
        else
        begin
            mode_r      <= mode_nxt;
            addr_r      <= addr_nxt;
            pend_r      <= pend_nxt;
            fill_par_r  <= fill_par_nxt;
            req_r       <= req_nxt;
            we_r        <= we_nxt;
            maddr_r     <= maddr_nxt;
            wdata_r     <= wdata_nxt;
            rd_buf_r    <= rd_buf_nxt;
            idle_r      <= idle_nxt;
            oe_r        <= oe_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Reply driven while oe_r is set: status while deselected, data while selected
    assign link_miso_out    = link_cs_n_in ? idle_r : miso_link_r;
    assign link_miso_oe_out = oe_r;
    assign mem_req_out      = req_r;
    assign mem_we_out       = we_r;
    assign mem_addr_out     = maddr_r;
    assign mem_wdata_out    = wdata_r;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_cmd_done;
        !link_cs_n_in && (ph_r == PH_CMD) && (bit_r == CMD_LAST_BIT);
    endsequence

    sequence s_word_done;
        !link_cs_n_in && (ph_r != PH_CMD) && (bit_r == WORD_LAST_BIT);
    endsequence

    property p_cmd_capture;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        s_cmd_done |=> (ph_r == PH_ADDR) && (bit_r == BIT_RST);
    endproperty
    a_cmd_capture: assert property (p_cmd_capture) else $error("command not taken");

    property p_addr_start;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        s_word_done and (ph_r == PH_ADDR) |=> (start_tgl_r != $past(start_tgl_r))
            && (ph_r == PH_DATA) && (addr_hold_r == $past(shin_sh));
    endproperty
    a_addr_start: assert property (p_addr_start) else $error("address not taken");

    property p_wr_word;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        s_word_done and (ph_r == PH_DATA) and (cmd_r == CMD_WRITE)
            |=> (wr_tgl_r != $past(wr_tgl_r));
    endproperty
    a_wr_word: assert property (p_wr_word) else $error("write word lost");

    property p_frame_end;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        link_cs_n_in |=> (ph_r == PH_CMD) && (bit_r == BIT_RST) && (shout_r == WORD_RST);
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame not abandoned");

    property p_msb_first;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        !link_cs_n_in |=> (shin_r[0] == $past(link_mosi_in)) && (shin_r[1] == $past(shin_r[0]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("shift order wrong");

    property p_reply_quiet;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (ph_r != PH_DATA) && !link_cs_n_in ##1 (ph_r != PH_DATA) |-> (miso_link_r == 1'b0);
    endproperty
    a_reply_quiet: assert property (p_reply_quiet) else $error("reply before data");

    property p_addr_inc;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        req_r && mem_ack_in && !start_p |=> (addr_r == 16'($past(addr_r) + 16'h0001));
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("address not advanced");

    property p_idle_level;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ##1 1'b1 |-> (idle_r == $past(cpu_halted_in));
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle reply wrong");

    property p_write_issue;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        wr_p && !start_p && (mode_r == SS_WRITE) |=> req_r && we_r && (wdata_r == wr_hold_r);
    endproperty
    a_write_issue: assert property (p_write_issue) else $error("write not issued");

    property p_req_hold;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        req_r && !mem_ack_in |=> req_r && $stable(maddr_r);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");

    property p_cmd_decode;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        start_p && (cmd_r == CMD_READ) |=> (mode_r == SS_READ) && (pend_r == PREFETCH);
    endproperty
    a_cmd_decode: assert property (p_cmd_decode) else $error("read not decoded");

endmodule

// [bench/dsp_master.sv]
`timescale 1ns/1ns
// ****
// Serial master model
// ****
module dsp_master
(
    output logic      link_clk_out,
    output logic      link_cs_n_out,
    output logic      link_mosi_out,
    input  wire logic link_miso_in
);
    logic [15:0] wd[8];
    logic [15:0] rd[8];
    int          n_glitch;

    // Clock rests low outside frames
    initial
    begin
        link_clk_out = 1'b0;
        link_cs_n_out = 1'b1;
        link_mosi_out = 1'b0;
        n_glitch = 0;
    end

    // master makes clock
    // Reply taken at the rise, then watched through the high phase
    task automatic bit_x(input logic b, output logic r);
        logic seen;
        link_mosi_out = b;
        #16 link_clk_out = 1'b1;
        r = link_miso_in;
        #15 seen = link_miso_in;
        if (seen !== r)
            n_glitch++;
        #1 link_clk_out = 1'b0;
    endtask

    task automatic shift(input logic [15:0] v, input int n, output logic [15:0] r);
        logic b;
        r = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            bit_x(v[i], b);
            r = {r[14:0], b};
        end
    endtask

    // select high clocks
    // Data line toggles while deselected so no stale level shows
    task automatic idle_clocks(input int n);
        logic b;
        link_cs_n_out = 1'b1;
        repeat (n)
            bit_x(~link_mosi_out, b);
    endtask

    // command, address, words; cut adds a partial word
    task automatic frame(input logic [7:0] cmd, input logic [15:0] addr, input int n,
                         input int cut);
        logic [15:0] r;
        idle_clocks(2);
        link_cs_n_out = 1'b0;
        shift({8'h00, cmd}, 8, r);
        shift(addr, 16, r);
        for (int k = 0; k < n; k++)
        begin
            shift(wd[k], 16, r);
            rd[k] = r;
        end
        if (cut > 0)
            shift(16'hffff, cut, r);
        #8 link_cs_n_out = 1'b1;
        // Data line moved apart from select; gap keeps back-to-back frames distinct
        #8 link_mosi_out = ~link_mosi_out;
        #16;
    endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ns
module testbench
    import dsp_pkg::*;
;
    logic        clk, rst_n, pin_sel, halted, ack, lclk, cs_n, mosi, miso, miso_oe, req, we;
    logic [15:0] addr, wdata, rdata;
    logic [15:0] mem[256];
    int          n_errors, compares, n_wr, base;

    // ****
    // Clock, memory side, instances
    // ****
    initial
    begin
        clk = 1'b0;
        forever
            #50 clk = ~clk;
    end

    // Ack one cycle after request; write lands with the ack
    always @(negedge clk)
    begin
        ack <= req && !ack && rst_n;
        if (req && !ack && rst_n)
        begin
            rdata <= mem[addr[7:0]];
            if (we)
            begin
                mem[addr[7:0]] <= wdata;
                n_wr <= n_wr + 1;
            end
        end
    end

    dsp_master m_u (.link_clk_out(lclk), .link_cs_n_out(cs_n), .link_mosi_out(mosi),
                    .link_miso_in(miso));
    dsp_top dut_u (.clk_sys_in(clk), .reset_n_in(rst_n), .link_clk_in(lclk),
        .link_cs_n_in(cs_n), .link_mosi_in(mosi), .link_miso_out(miso),
        .link_miso_oe_out(miso_oe), .port_enable_select_in(pin_sel),
        .cpu_halted_in(halted), .mem_req_out(req), .mem_we_out(we), .mem_addr_out(addr),
        .mem_wdata_out(wdata), .mem_rdata_in(rdata), .mem_ack_in(ack));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Bounded wait for the memory side to see n writes in all
    task automatic wait_wr(input int n);
        for (int t = 0; t < 60 && n_wr < n; t++)
            @(negedge clk);
        if (n_wr < n)
        begin
            n_errors++;
            $display("BAD write count exp %0d got %0d", n, n_wr);
            tally_and_finish();
        end
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_idle();
        for (int h = 0; h < 2; h++)
        begin
            halted = h[0];
            repeat (10) @(negedge clk);
            chk("idle reply", {15'h0, h[0]}, {15'h0, miso});
        end
        pin_sel = 1'b0;
        repeat (10) @(negedge clk);
        chk("oe off", 16'h0, {15'h0, miso_oe});
        pin_sel = 1'b1;
        repeat (10) @(negedge clk);
        chk("oe on", 16'h1, {15'h0, miso_oe});
        $display("test idle done");
    endtask

    // Block write then block read, processor halted then running
    task automatic t_block();
        base = n_wr;
        halted = 1'b1;
        m_u.wd = '{16'h1111, 16'h8222, 16'h3333, 0, 0, 0, 0, 0};
        m_u.frame(CMD_WRITE, 16'h0010, 3, 0);
        wait_wr(base + 3);
        for (int k = 0; k < 3; k++)
            chk("block write", m_u.wd[k], mem[16 + k]);
        halted = 1'b0;
        // Idle level settles before the link clock runs again
        repeat (2) @(negedge clk);
        m_u.frame(CMD_READ, 16'h0010, 5, 0);
        chk("filler", 16'h0, m_u.rd[0] | m_u.rd[1]);
        for (int k = 0; k < 3; k++)
            chk("block read", m_u.wd[k], m_u.rd[k + 2]);
        chk("reply in high phase", 16'h0, m_u.n_glitch[15:0]);
        $display("test block done");
    endtask

    // Single word, frame cut mid-word, then recovery and an unknown command
    task automatic t_single_cut();
        base = n_wr;
        m_u.wd[0] = 16'h4a5c;
        m_u.frame(CMD_WRITE, 16'h0020, 1, 8);
        wait_wr(base + 1);
        repeat (20) @(negedge clk);
        chk("single write", 16'h4a5c, mem[32]);
        chk("cut word", 16'hc021, mem[33]);
        m_u.frame(CMD_READ, 16'h0020, 3, 0);
        chk("single read", 16'h4a5c, m_u.rd[2]);
        m_u.frame(8'h55, 16'h0010, 3, 0);
        repeat (20) @(negedge clk);
        chk("unknown writes", base[15:0] + 16'h1, n_wr[15:0]);
        chk("unknown reply", 16'h0, m_u.rd[2]);
        $display("test single and cut done");
    endtask

    initial
    begin
        rst_n = 1'b0;
        pin_sel = 1'b1;
        halted = 1'b0;
        ack = 1'b0;
        rdata = '0;
        {n_wr, n_errors, compares} = '0;
        for (int i = 0; i < 256; i++)
            mem[i] = 16'hc000 | 16'(i);
        fork
            begin
                repeat (20) @(negedge clk);
                rst_n = 1'b1;
            end
            m_u.idle_clocks(70);
        join
        repeat (3) @(negedge clk);
        t_idle();
        t_block();
        t_single_cut();
        tally_and_finish();
    end

    // Hang guard
    initial
    begin
        #4000000;
        n_errors++;
        $display("BAD run time exp done got hung");
        tally_and_finish();
    end
endmodule
